// *** pkg/blrr_cfg.svh ***
// Constants of the boot loader run and reset command block
`ifndef BLRR_CFG_SVH
`define BLRR_CFG_SVH

// ---------------------------------------------------------------
// Packet codes
// ---------------------------------------------------------------
`define BLRR_CMD_RUN     8'h22
`define BLRR_CMD_RESET   8'h25
`define BLRR_ACK         8'hCC
`define BLRR_NAK         8'h33
`define BLRR_ZERO        8'h00

// ---------------------------------------------------------------
// Packet lengths and layout
// ---------------------------------------------------------------
`define BLRR_LEN_RUN     8'h07
`define BLRR_LEN_RESET   8'h03
`define BLRR_LEN_MIN     8'h03
`define BLRR_HDR_BYTES   8'h03

// ---------------------------------------------------------------
// Buffer shape
// ---------------------------------------------------------------
`define BLRR_BYTE_W      8
`define BLRR_FIFO_DEPTH  16

`endif

// *** pkg/blrr_pkg.sv ***
// Types of the boot loader run and reset command block
package blrr_pkg;

    // ---------------------------------------------------------------
    // Parser states, one-hot
    // ---------------------------------------------------------------
    typedef enum logic [5:0] {
        BLRR_IDLE  = 6'h01,
        BLRR_SUM   = 6'h02,
        BLRR_DATA  = 6'h04,
        BLRR_CHECK = 6'h08,
        BLRR_REPLY = 6'h10,
        BLRR_WAIT  = 6'h20
    } blrr_state_t;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } blrr_byte_t;

    typedef struct packed {
        logic        jump;
        logic        restart;
        logic [31:0] addr;
    } blrr_action_t;

endpackage

// *** rtl/blrr_fifo.sv ***
// Byte FIFO with valid and ready on both sides
`timescale 1ns/100ps
module blrr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push;
    wire              pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
            rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
            count_reg  <= (AW+1)'(count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule

// *** rtl/blrr_txreg.sv ***
// One-byte holding register for reply bytes toward the link
`timescale 1ns/100ps
module blrr_txreg (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic      [7:0] out_data
);
    logic       full_reg;
    logic [7:0] data_reg;

    assign in_ready  = !full_reg;
    assign out_valid = full_reg;
    assign out_data  = data_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            full_reg <= 1'b0;
            data_reg <= 8'h00;
        end else if (in_valid && in_ready) begin
            full_reg <= 1'b1;
            data_reg <= in_data;
        end else if (full_reg && out_ready) begin
            full_reg <= 1'b0;
        end
    end
endmodule

// *** rtl/blrr_cmd.sv ***
// Run and restart command interpreter of the serial boot loader
`timescale 1ns/100ps
`include "blrr_cfg.svh"

// How it works
// (R1) Command byte 22 hex in the data starts execution at a given address.
// (R2) Execute packet is seven bytes, address MSB first, sum over bytes three to seven.
// (R3) Acknowledge leaves the link before the jump is signalled.
// (R4) Restart packet is three bytes, command 25 hex, sum equals that byte.
// (R5) Acknowledge leaves the link before the software reset is raised.
// (R6) Restart raises a full device reset; execute only jumps.
// (R7) Host may send restart after a critical error to start over.
// (R8) First byte is total length; second is 8-bit sum of data bytes.
// (R9) Reply CC hex for an intact packet, 33 hex otherwise.
// (R10) Leading zero bytes are skipped; first non-zero byte starts the packet.
// (R11) Bad length or sum on execute or restart gives NAK and no action.
module blrr_cmd (
    input  wire logic                  CLOCK,
    input  wire logic                  RST_N,
    input  wire blrr_pkg::blrr_byte_t  RX_BYTE,
    output logic                       RX_READY,
    output blrr_pkg::blrr_byte_t       TX_BYTE,
    input  wire logic                  TX_READY,
    output blrr_pkg::blrr_action_t     ACTION
);
    import blrr_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    blrr_state_t  st_reg;
    blrr_state_t  st_next;
    logic [7:0]   len_reg;
    logic [7:0]   chk_reg;
    logic [7:0]   sum_reg;
    logic [7:0]   idx_reg;
    logic [7:0]   cmd_reg;
    logic [31:0]  addr_reg;
    logic [7:0]   reply_reg;
    logic         jump_reg;
    logic         restart_reg;
    logic         ack_seen_reg;
    logic         q_valid;
    logic [7:0]   q_data;
    logic         tx_in_ready;
    logic         tx_valid;
    logic [7:0]   tx_data;
    wire          q_ready;
    wire          pop;
    wire          last_data;
    wire          sum_ok;
    wire          len_ok;
    wire          intact;
    wire          tx_push;
    wire          tx_done;
    wire          tx_idle;
    wire          is_run;
    wire          is_reset;
    wire          act_go;

    // ---------------------------------------------------------------
    // Input buffer
    // ---------------------------------------------------------------
    blrr_fifo #(
        .WIDTH (`BLRR_BYTE_W),
        .DEPTH (`BLRR_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .in_valid  (RX_BYTE.valid),
        .in_ready  (RX_READY),
        .in_data   (RX_BYTE.data),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    // ---------------------------------------------------------------
    // Reply holding register
    // ---------------------------------------------------------------
    blrr_txreg u_tx (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .in_valid  (tx_push),
        .in_ready  (tx_in_ready),
        .in_data   (reply_reg),
        .out_valid (tx_valid),
        .out_ready (TX_READY),
        .out_data  (tx_data)
    );

    assign TX_BYTE.valid = tx_valid;
    assign TX_BYTE.data  = tx_data;
    assign ACTION.jump    = jump_reg;
    assign ACTION.restart = restart_reg;
    assign ACTION.addr    = addr_reg;

    // ---------------------------------------------------------------
    // Decoding
    // ---------------------------------------------------------------
    assign q_ready   = (st_reg == BLRR_IDLE) || (st_reg == BLRR_SUM) || (st_reg == BLRR_DATA);
    assign pop       = q_valid && q_ready;
    assign last_data = (idx_reg == 8'(len_reg - `BLRR_HDR_BYTES));
    assign is_run    = (cmd_reg == `BLRR_CMD_RUN); // R1
    assign is_reset  = (cmd_reg == `BLRR_CMD_RESET); // R4
    assign sum_ok    = (sum_reg == chk_reg); // R8
    assign len_ok    = (len_reg >= `BLRR_LEN_MIN)
                    && (!is_run || len_reg == `BLRR_LEN_RUN) // R2
                    && (!is_reset || len_reg == `BLRR_LEN_RESET); // R4
    assign intact    = sum_ok && len_ok; // R11
    assign tx_push   = (st_reg == BLRR_REPLY);
    assign tx_done   = tx_valid && TX_READY;
    assign tx_idle   = !tx_valid;
    assign act_go    = (st_reg == BLRR_WAIT) && tx_idle; // R3 R5

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            BLRR_IDLE: begin
                if (pop && q_data != `BLRR_ZERO) begin // R10
                    st_next = BLRR_SUM;
                end
            end
            BLRR_SUM: begin
                if (pop) begin
                    st_next = (len_reg < `BLRR_LEN_MIN) ? BLRR_CHECK : BLRR_DATA;
                end
            end
            BLRR_DATA: begin
                if (pop && last_data) begin
                    st_next = BLRR_CHECK;
                end
            end
            BLRR_CHECK: begin
                st_next = BLRR_REPLY;
            end
            BLRR_REPLY: begin
                if (tx_in_ready) begin
                    if (reply_reg == `BLRR_ACK && (is_run || is_reset)) begin
                        st_next = BLRR_WAIT;
                    end else begin
                        st_next = BLRR_IDLE; // R11
                    end
                end
            end
            BLRR_WAIT: begin
                if (tx_idle) begin // R3 R5
                    st_next = BLRR_IDLE;
                end
            end
            default: begin
                st_next = BLRR_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Packet capture
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_reg    <= BLRR_IDLE;
            len_reg   <= 8'h00;
            chk_reg   <= 8'h00;
            sum_reg   <= 8'h00;
            idx_reg   <= 8'h00;
            cmd_reg   <= 8'h00;
            addr_reg  <= 32'h0000_0000;
            reply_reg <= 8'h00;
        end else begin
            st_reg <= st_next;
            if (st_reg == BLRR_IDLE && pop) begin
                len_reg <= q_data; // R8
            end
            if (st_reg == BLRR_SUM && pop) begin
                chk_reg <= q_data;
                sum_reg <= 8'h00;
                idx_reg <= 8'h00;
                cmd_reg <= 8'h00;
            end
            if (st_reg == BLRR_DATA && pop) begin
                sum_reg <= 8'(sum_reg + q_data); // R8
                idx_reg <= 8'(idx_reg + 8'h01);
                if (idx_reg == 8'h00) begin
                    cmd_reg <= q_data; // R1
                end else begin
                    addr_reg <= {addr_reg[23:0], q_data}; // R2
                end
            end
            if (st_reg == BLRR_CHECK) begin
                reply_reg <= intact ? `BLRR_ACK : `BLRR_NAK; // R9
            end
        end
    end

    // ---------------------------------------------------------------
    // Actions
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            jump_reg     <= 1'b0;
            restart_reg  <= 1'b0;
            ack_seen_reg <= 1'b0;
        end else begin
            jump_reg     <= act_go && is_run; // R3
            restart_reg  <= act_go && is_reset; // R5 R6
            if (tx_done && tx_data == `BLRR_ACK) begin
                ack_seen_reg <= 1'b1;
            end else if (st_reg == BLRR_CHECK) begin
                ack_seen_reg <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_ack_sent;
        ack_seen_reg && !tx_valid;
    endsequence

    sequence s_nak_queued;
        tx_push && tx_in_ready && reply_reg == `BLRR_NAK;
    endsequence

    a_run_decode: assert property ( // R1
        @(posedge CLOCK) disable iff (!RST_N)
        ACTION.jump |-> $past(cmd_reg) == `BLRR_CMD_RUN && $past(len_reg) == `BLRR_LEN_RUN)
        else $error("jump without a valid execute packet");

    a_run_addr: assert property ( // R2
        @(posedge CLOCK) disable iff (!RST_N)
        ACTION.jump |-> ACTION.addr == $past(addr_reg, 2))
        else $error("jump address changed after check");

    a_ack_before_jump: assert property ( // R3
        @(posedge CLOCK) disable iff (!RST_N)
        $rose(ACTION.jump) |-> $past(ack_seen_reg) && $past(tx_valid) == 1'b0)
        else $error("jump before acknowledge left the link");

    a_restart_decode: assert property ( // R4
        @(posedge CLOCK) disable iff (!RST_N)
        ACTION.restart |-> $past(cmd_reg) == `BLRR_CMD_RESET && $past(len_reg) == `BLRR_LEN_RESET)
        else $error("restart without a valid restart packet");

    a_ack_before_reset: assert property ( // R5
        @(posedge CLOCK) disable iff (!RST_N)
        ACTION.restart |-> $past(ack_seen_reg))
        else $error("restart before acknowledge");

    a_restart_only: assert property ( // R6
        @(posedge CLOCK) disable iff (!RST_N)
        ACTION.restart |-> !ACTION.jump ##1 !ACTION.restart)
        else $error("restart not a lone pulse");

    a_sum_check: assert property ( // R8
        @(posedge CLOCK) disable iff (!RST_N)
        (st_reg == BLRR_CHECK && sum_reg != chk_reg) |=> reply_reg == `BLRR_NAK)
        else $error("bad sum not refused");

    a_reply_code: assert property ( // R9
        @(posedge CLOCK) disable iff (!RST_N)
        tx_push |-> reply_reg == `BLRR_ACK || reply_reg == `BLRR_NAK)
        else $error("reply is neither ACK nor NAK");

    a_zero_skip: assert property ( // R10
        @(posedge CLOCK) disable iff (!RST_N)
        (st_reg == BLRR_IDLE && pop && q_data == `BLRR_ZERO) |=> st_reg == BLRR_IDLE)
        else $error("leading zero started a packet");

    a_nak_no_act: assert property ( // R11
        @(posedge CLOCK) disable iff (!RST_N)
        s_nak_queued |=> (!ACTION.jump && !ACTION.restart) [*4])
        else $error("action after negative acknowledge");

    a_ack_then_act: assert property ( // R3
        @(posedge CLOCK) disable iff (!RST_N)
        (st_reg == BLRR_WAIT) and s_ack_sent |=> ACTION.jump || ACTION.restart)
        else $error("acknowledged command not carried out");

    a_jump_pulse: assert property ( // R3
        @(posedge CLOCK) disable iff (!RST_N)
        ACTION.jump |=> !ACTION.jump)
        else $error("jump longer than one cycle");

    a_len_refuse: assert property ( // R11
        @(posedge CLOCK) disable iff (!RST_N)
        (st_reg == BLRR_CHECK && !len_ok) |=> reply_reg == `BLRR_NAK)
        else $error("bad length not refused");

    a_good_ack: assert property ( // R9
        @(posedge CLOCK) disable iff (!RST_N)
        (st_reg == BLRR_CHECK && sum_ok && len_ok) |=> reply_reg == `BLRR_ACK)
        else $error("intact packet not acknowledged");

    a_reply_hold: assert property ( // R9
        @(posedge CLOCK) disable iff (!RST_N)
        (TX_BYTE.valid && !TX_READY) |=> TX_BYTE.valid && $stable(TX_BYTE.data))
        else $error("reply dropped before the link took it");

    a_len_capture: assert property ( // R10
        @(posedge CLOCK) disable iff (!RST_N)
        (st_reg == BLRR_IDLE && pop && q_data != `BLRR_ZERO)
        |=> st_reg == BLRR_SUM && len_reg == $past(q_data))
        else $error("first non-zero byte not taken as length");
endmodule

// *** verification/blrr_host.sv ***
// Host side model of the serial loader link
`timescale 1ns/100ps
module blrr_host (
    input  wire logic                 CLOCK,
    input  wire logic                 RX_READY,
    input  wire blrr_pkg::blrr_byte_t TX_BYTE,
    output blrr_pkg::blrr_byte_t      RX_BYTE,
    output logic                      TX_READY
);
    import blrr_pkg::*;
    logic [7:0] replies [$];
    logic [7:0] last;
    time        ack_time;
    int         stall;
    int         wait_cnt;

    initial begin
        RX_BYTE  = 9'h000;
        last     = 8'h00;
        ack_time = 0;
        stall    = 0;
        wait_cnt = 0;
    end

    // ---------------------------------------------------------------
    // Byte offer, held until the device takes it or 300 cycles pass
    // ---------------------------------------------------------------
    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge CLOCK);
        RX_BYTE = {1'b1, b};
        while (RX_READY !== 1'b1 && n < 300) begin
            n++;
            @(negedge CLOCK);
        end
        @(posedge CLOCK);
        last = b;
    endtask

    // Released line shows the inverse of the last byte
    task automatic idle();
        @(negedge CLOCK);
        RX_BYTE = {1'b0, ~last};
    endtask

    // ---------------------------------------------------------------
    // Reply acceptance, slowed by the stall count
    // ---------------------------------------------------------------
    always @(negedge CLOCK) begin
        if (TX_BYTE.valid === 1'b1 && wait_cnt < stall) begin
            wait_cnt = wait_cnt + 1;
            TX_READY = 1'b0;
        end else begin
            TX_READY = 1'b1;
        end
    end

    always @(posedge CLOCK) begin
        if (TX_BYTE.valid === 1'b1 && TX_READY === 1'b1) begin
            replies.push_back(TX_BYTE.data);
            ack_time = $time;
            wait_cnt = 0;
        end
    end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench of the run and restart command interpreter
`timescale 1ns/100ps
module testbench;
    import blrr_pkg::*;
    localparam int LIMIT = 3000;
    logic         clock;
    logic         rst_n;
    blrr_byte_t   rx_byte;
    logic         rx_ready;
    blrr_byte_t   tx_byte;
    logic         tx_ready;
    blrr_action_t action;
    int           err_count;
    int           checked;
    int           cyc;
    int           jump_cnt;
    int           rst_cnt;
    time          act_time;

    blrr_cmd i_blrr_cmd (.CLOCK(clock), .RST_N(rst_n), .RX_BYTE(rx_byte),
        .RX_READY(rx_ready), .TX_BYTE(tx_byte), .TX_READY(tx_ready), .ACTION(action));
    blrr_host i_host (.CLOCK(clock), .RX_READY(rx_ready), .TX_BYTE(tx_byte),
        .RX_BYTE(rx_byte), .TX_READY(tx_ready));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ---------------------------------------------------------------
    // Action monitor and run limit
    // ---------------------------------------------------------------
    always @(negedge clock) begin
        cyc++;
        if (action.jump === 1'b1) begin
            jump_cnt++;
            act_time = $time;
        end
        if (action.restart === 1'b1) begin
            rst_cnt++;
            act_time = $time;
        end
        if (cyc == LIMIT) begin
            err_count++;
            end_sim();
        end
    end

    // ---------------------------------------------------------------
    // Shared helpers
    // ---------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tx_pkt(input logic [63:0] p, input int n);
        for (int i = 0; i < n; i++) begin
            i_host.send(p[63-8*i -: 8]);
        end
    endtask

    task automatic wait_reply(input logic [7:0] exp);
        int n;
        n = 0;
        while (i_host.replies.size() == 0 && n < 300) begin
            n++;
            @(negedge clock);
        end
        if (i_host.replies.size() > 0) begin
            check(i_host.replies.pop_front(), exp);
        end else begin
            check(32'hFFFFFFFF, exp);
        end
    endtask

    // Whole packet: reply code, action counts, address and order
    task automatic run_pkt(input logic [63:0] p, input int n, input logic [7:0] rep,
                           input int j, input int r, input logic [31:0] addr);
        jump_cnt = 0;
        rst_cnt  = 0;
        act_time = 0;
        tx_pkt(p, n);
        i_host.idle();
        wait_reply(rep);
        repeat (8) @(negedge clock);
        check(jump_cnt, j);
        check(rst_cnt, r);
        if (j > 0) check(action.addr, addr);
        if (j + r > 0) check(act_time > i_host.ack_time + 100, 1);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        repeat (3) @(posedge clock);
        @(negedge clock);
        check(rx_ready, 1'b1);
        check(tx_byte, 9'h000);
        check({action.jump, action.restart}, 2'h0);
        check(action.addr, 32'h00000000);
        rst_n = 1'b1;
        $display("test reset done");
    endtask

    task automatic t_run();
        i_host.send(8'h00);
        i_host.send(8'h00);
        run_pkt(64'h0736221234567800, 7, 8'hCC, 1, 0, 32'h12345678);
        run_pkt(64'h071E22FFFFFFFF00, 7, 8'hCC, 1, 0, 32'hFFFFFFFF);
        $display("test run done");
    endtask

    task automatic t_restart();
        i_host.stall = 3;
        run_pkt(64'h0325250000000000, 3, 8'hCC, 0, 1, 32'h0);
        i_host.stall = 0;
        $display("test restart done");
    endtask

    task automatic t_bad();
        run_pkt(64'h0700221234567800, 7, 8'h33, 0, 0, 32'h0);
        run_pkt(64'h0425250000000000, 4, 8'h33, 0, 0, 32'h0);
        run_pkt(64'h0200000000000000, 2, 8'h33, 0, 0, 32'h0);
        run_pkt(64'h0322220000000000, 3, 8'h33, 0, 0, 32'h0);
        run_pkt(64'h0320200000000000, 3, 8'hCC, 0, 0, 32'h0);
        run_pkt(64'h0325250000000000, 3, 8'hCC, 0, 1, 32'h0);
        $display("test bad packets done");
    endtask

    task automatic t_fill();
        i_host.stall = 100000;
        rst_cnt = 0;
        tx_pkt(64'h0325250000000000, 3);
        for (int i = 0; i < 16; i++) begin
            i_host.send(8'h00);
        end
        i_host.idle();
        check(rx_ready, 1'b0);
        repeat (4) @(negedge clock);
        check(rx_ready, 1'b0);
        check(rst_cnt, 0);
        i_host.stall = 0;
        wait_reply(8'hCC);
        repeat (8) @(negedge clock);
        check(rst_cnt, 1);
        run_pkt(64'h0325250000000000, 3, 8'hCC, 0, 1, 32'h0);
        check(rx_ready, 1'b1);
        $display("test fill done");
    endtask

    initial begin
        rst_n = 1'b0;
        t_reset();
        t_run();
        t_restart();
        t_bad();
        t_fill();
        end_sim();
    end
endmodule
